// [design/lp_ctl_pkg.sv]
package lp_ctl_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFF_LINK_CONTROL_ONE = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_LINK_CONTROL_TWO = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_LINK_STATE_VECTOR = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_EVENT_CLEAR = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_EVENT_ENABLE = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_MODE_STATUS = 5'h18;

    // Field positions
    localparam int unsigned BIT_WAKEUP_CLOCK_MODE_SEL = 0;
    localparam int unsigned BIT_ANALOG_LOOPBACK_SEL = 0;
    localparam int unsigned BIT_DIGITAL_LOOPBACK_SEL = 1;
    localparam int unsigned EV_WAIT_WAKE = 0;
    localparam int unsigned EV_STOP_WAKE = 1;
    localparam int unsigned EV_IDLE_FOUND = 2;
    localparam int unsigned EV_W = 3;

    // Reset values
    localparam logic [DATA_W-1:0] RST_CONTROL_ONE = 8'h00;
    localparam logic [DATA_W-1:0] RST_CONTROL_TWO = 8'h00;
    localparam logic [EV_W-1:0] RST_EVENT_ENABLE = 3'h0;

    // State vector codes
    localparam logic [DATA_W-1:0] VEC_NONE = 8'h00;
    localparam logic [DATA_W-1:0] VEC_WAKEUP = 8'h20;

    // Timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned IDLE_BUS_US = 300;
    localparam int unsigned IDLE_BUS_CYC = (IDLE_BUS_US * (CLK_HZ / 1000000));

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAIT = 2'b01,
        ST_STOP = 2'b11,
        ST_IDLE_HUNT = 2'b10
    } lp_state_t;
endpackage

// [design/wake_edge_latch.sv]
`timescale 1ns/100ps
// Catches a passive-to-active edge with no clock running; cleared while disarmed
module wake_edge_latch (
    input  wire logic bus_rx_i,
    input  wire logic armed_i,
    output logic      caught_o
);
    wire logic clear;

    assign clear = ~armed_i;

    always_ff @(posedge bus_rx_i or posedge clear) begin
        if (clear) begin
            caught_o <= 1'b0;
        end else begin
            caught_o <= 1'b1;
        end
    end
endmodule

// [design/lp_loopback_ctl.sv]
`timescale 1ns/100ps
module lp_loopback_ctl #(
    parameter int unsigned IDLE_CYC = lp_ctl_pkg::IDLE_BUS_CYC
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic [lp_ctl_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [lp_ctl_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [lp_ctl_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                        cpu_wait_i,
    input  wire logic                        cpu_stop_i,
    input  wire logic                        bus_rx_i,
    output logic                             bus_tx_o,
    input  wire logic                        tx_digital_out_i,
    output logic                             rx_digital_in_o,
    output logic                             tx_allowed_o,
    output logic                             mod_clk_run_o,
    output logic                             irq_o,
    output logic                             wake_nmi_o
);
    import lp_ctl_pkg::*;

    localparam int unsigned CNT_W = $clog2(IDLE_CYC + 1);
    // Edges the wake synchroniser needs to flush a catch left by the last wakeup
    localparam logic [1:0] STOP_SETTLE = 2'h2;

    lp_state_t            state;
    lp_state_t            next_state;
    logic [DATA_W-1:0]    control_one;
    logic [DATA_W-1:0]    control_two;
    logic [EV_W-1:0]      ev_status;
    logic [EV_W-1:0]      ev_enable;
    logic [EV_W-1:0]      ev_set;
    logic                 cpu_stopped;
    logic                 msg_lost;
    logic                 analog_loopback_sel_prev;
    logic                 hunt_pending;
    logic [CNT_W-1:0]     idle_cnt;
    logic [1:0]           sync_in;
    logic [1:0]           sync_a;
    logic [1:0]           sync_b;
    logic                 rx_prev;
    logic                 latch_armed;
    logic                 latch_caught;
    logic                 rx_sync;
    logic                 caught_sync;
    logic                 rx_rise;
    logic                 wakeup_clock_mode_sel;
    logic                 analog_loopback_sel;
    logic                 digital_loopback_sel;
    logic                 loop_any;
    logic                 analog_loopback_sel_fall;
    logic [1:0]           stop_age;
    logic                 stop_settled;
    logic                 stop_wake;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Low-power mode picked by the mode select bit
    function automatic lp_state_t lp_target(input logic sel);
        lp_target = sel ? ST_STOP : ST_WAIT;
    endfunction

    assign wakeup_clock_mode_sel = control_one[BIT_WAKEUP_CLOCK_MODE_SEL];
    assign analog_loopback_sel = control_two[BIT_ANALOG_LOOPBACK_SEL];
    assign digital_loopback_sel = control_two[BIT_DIGITAL_LOOPBACK_SEL];
    assign loop_any = analog_loopback_sel | digital_loopback_sel;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: bus pin and the clockless wake latch
    assign sync_in = {latch_caught, bus_rx_i};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    sync_a[g] <= 1'b0;
                    sync_b[g] <= 1'b0;
                end else begin
                    sync_a[g] <= sync_in[g];
                    sync_b[g] <= sync_a[g];
                end
            end
        end
    endgenerate

    assign rx_sync = sync_b[0];
    assign caught_sync = sync_b[1];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_prev <= 1'b0;
        end else begin
            rx_prev <= rx_sync;
        end
    end

    // Passive-to-active edge on the synchronised bus input
    assign rx_rise = rx_sync & ~rx_prev;

    ////////////////////////////////////////////////////////////////////////
    // Wake edge latch, armed only in stop without loopback
    wake_edge_latch u_wake_latch (
        .bus_rx_i (bus_rx_i),
        .armed_i  (latch_armed),
        .caught_o (latch_caught)
    );

    // Disarming clears the latch, so no catch outlives its stop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_armed <= 1'b0;
        end else begin
            latch_armed <= (next_state == ST_STOP) && !loop_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power mode sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (cpu_wait_i) begin
                    next_state = lp_target(wakeup_clock_mode_sel);
                end else if (cpu_stop_i) begin
                    next_state = lp_target(wakeup_clock_mode_sel);
                end else if (hunt_pending) begin
                    next_state = ST_IDLE_HUNT;
                end
            end
            ST_WAIT: begin
                if (rx_rise && !loop_any) begin
                    next_state = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    next_state = ST_RUN;
                end
            end
            ST_IDLE_HUNT: begin
                if (cpu_wait_i || cpu_stop_i) begin
                    next_state = lp_target(wakeup_clock_mode_sel);
                end else if (idle_cnt == CNT_W'(IDLE_CYC)) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                // Unused code: fall back to run
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // A catch still in the synchroniser from the last wakeup must not end
    // a stop entered right after it; a real catch needs the full chain anyway
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stop_age <= '0;
        end else if (state != ST_STOP) begin
            stop_age <= '0;
        end else if (stop_age != STOP_SETTLE) begin
            stop_age <= stop_age + 2'h1;
        end
    end

    assign stop_settled = (stop_age == STOP_SETTLE);
    assign stop_wake = caught_sync && stop_settled;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_stopped <= 1'b0;
            msg_lost <= 1'b0;
        end else begin
            if (state != ST_STOP && next_state == ST_STOP) begin
                cpu_stopped <= cpu_stop_i;
            end
            if (state == ST_STOP && next_state == ST_RUN) begin
                msg_lost <= cpu_stopped;
            end else if (wr_i && hit(addr_i, OFF_EVENT_CLEAR) && wdata_i[EV_STOP_WAKE]) begin
                msg_lost <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle bus hunt after analog loopback is released
    assign analog_loopback_sel_fall = analog_loopback_sel_prev & ~analog_loopback_sel;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_loopback_sel_prev <= 1'b0;
            hunt_pending <= 1'b0;
        end else begin
            analog_loopback_sel_prev <= analog_loopback_sel;
            if (analog_loopback_sel_fall) begin
                hunt_pending <= 1'b1;
            end else if (ev_set[EV_IDLE_FOUND]) begin
                // Kept through a low-power trip so the hunt is never skipped
                hunt_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_cnt <= '0;
        end else if (state != ST_IDLE_HUNT || rx_sync) begin
            idle_cnt <= '0;
        end else if (idle_cnt != CNT_W'(IDLE_CYC)) begin
            idle_cnt <= idle_cnt + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit and receive routing
    always_comb begin
        if (digital_loopback_sel) begin
            rx_digital_in_o = tx_digital_out_i;
            bus_tx_o = 1'b0;
        end else begin
            rx_digital_in_o = rx_sync;
            bus_tx_o = tx_digital_out_i & tx_allowed_o;
        end
    end

    // No driving in wait, stop or while hunting for idle
    assign tx_allowed_o = (state == ST_RUN) && !hunt_pending && !analog_loopback_sel_fall;
    assign mod_clk_run_o = (state != ST_STOP);

    ////////////////////////////////////////////////////////////////////////
    // Events and interrupts
    // One-cycle event pulses; the status bits keep them
    always_comb begin
        ev_set = '0;
        ev_set[EV_WAIT_WAKE] = (state == ST_WAIT) && (next_state == ST_RUN);
        ev_set[EV_STOP_WAKE] = (state == ST_STOP) && (next_state == ST_RUN);
        ev_set[EV_IDLE_FOUND] = (state == ST_IDLE_HUNT) && (next_state == ST_RUN);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_status <= '0;
        end else begin
            // Set wins over a clear in the same cycle
            if (wr_i && hit(addr_i, OFF_EVENT_CLEAR)) begin
                ev_status <= (ev_status & ~wdata_i[EV_W-1:0]) | ev_set;
            end else begin
                ev_status <= ev_status | ev_set;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_enable <= RST_EVENT_ENABLE;
        end else if (wr_i && hit(addr_i, OFF_EVENT_ENABLE)) begin
            ev_enable <= wdata_i[EV_W-1:0];
        end
    end

    // Stop wakeup ignores the enable mask
    assign wake_nmi_o = ev_status[EV_STOP_WAKE];
    assign irq_o = |(ev_status & ev_enable);

    ////////////////////////////////////////////////////////////////////////
    // Control registers: only rst_i clears them, never a mode change
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_one <= RST_CONTROL_ONE;
            control_two <= RST_CONTROL_TWO;
        end else if (wr_i) begin
            if (hit(addr_i, OFF_LINK_CONTROL_ONE)) begin
                control_one <= wdata_i;
            end
            if (hit(addr_i, OFF_LINK_CONTROL_TWO)) begin
                control_two <= wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                OFF_LINK_CONTROL_ONE: rdata_o <= control_one;
                OFF_LINK_CONTROL_TWO: rdata_o <= control_two;
                OFF_LINK_STATE_VECTOR: begin
                    // Only a stop wakeup gives a vector; every other event reads as none
                    rdata_o <= ev_status[EV_STOP_WAKE] ? VEC_WAKEUP : VEC_NONE;
                end
                OFF_EVENT_STATUS: rdata_o <= DATA_W'(ev_status);
                OFF_EVENT_ENABLE: rdata_o <= DATA_W'(ev_enable);
                OFF_MODE_STATUS: begin
                    rdata_o <= DATA_W'({msg_lost, hunt_pending, state});
                end
                // Unmapped and write-only offsets read zero
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end
endmodule

// [verif/lp_ctl_assertions.sv]
`timescale 1ns/100ps
module lp_ctl_assertions
    import lp_ctl_pkg::*;
#(
    parameter int unsigned IDLE_CYC = 20
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              cpu_wait_i,
    input wire logic              cpu_stop_i,
    input wire logic              bus_rx_i,
    input wire logic              bus_tx_o,
    input wire logic              tx_digital_out_i,
    input wire logic              rx_digital_in_o,
    input wire logic              tx_allowed_o,
    input wire logic              mod_clk_run_o,
    input wire logic              irq_o,
    input wire logic              wake_nmi_o
);
    logic            wakeup_clock_mode_sel;
    logic            loop_on;
    logic            dl;
    logic            in_wait;
    logic [EV_W-1:0] en;
    logic            lp_req;
    assign lp_req = cpu_wait_i | cpu_stop_i;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the software-written control bits
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wakeup_clock_mode_sel <= 1'b0;
            loop_on <= 1'b0;
            dl <= 1'b0;
            en <= '0;
        end else if (wr_i) begin
            if (addr_i == OFF_LINK_CONTROL_ONE) wakeup_clock_mode_sel <= wdata_i[0];
            if (addr_i == OFF_LINK_CONTROL_TWO) loop_on <= |wdata_i[1:0];
            if (addr_i == OFF_LINK_CONTROL_TWO) dl <= wdata_i[1];
            if (addr_i == OFF_EVENT_ENABLE) en <= wdata_i[EV_W-1:0];
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) in_wait <= 1'b0;
        else if (lp_req && !wakeup_clock_mode_sel && tx_allowed_o) in_wait <= 1'b1;
        else if (tx_allowed_o) in_wait <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_tx_gate: assert property (bus_tx_o |-> tx_digital_out_i && tx_allowed_o && !dl)
        else $error("transmit driven while not allowed");
    a_wait_entry: assert property (lp_req && !wakeup_clock_mode_sel && tx_allowed_o |=> !tx_allowed_o && mod_clk_run_o)
        else $error("wait mode not entered");
    a_stop_entry: assert property (lp_req && wakeup_clock_mode_sel && tx_allowed_o |=> !mod_clk_run_o)
        else $error("stop mode not entered");
    a_stop_wake: assert property (!mod_clk_run_o && !$past(mod_clk_run_o) && !$past(mod_clk_run_o, 2)
        && !loop_on && $rose(bus_rx_i) |-> ##[1:5] mod_clk_run_o)
        else $error("no wake from stop");
    a_wait_wake: assert property (in_wait && !loop_on && $rose(bus_rx_i) |-> ##[1:5] tx_allowed_o)
        else $error("no wake from wait");
    a_loop_no_wake: assert property (loop_on && !mod_clk_run_o && !wr_i |=> !mod_clk_run_o)
        else $error("woke while in loopback");
    a_nmi_hold: assert property (wake_nmi_o && !(wr_i && addr_i == OFF_EVENT_CLEAR
        && wdata_i[EV_STOP_WAKE]) |=> wake_nmi_o)
        else $error("wake request lost");
    a_irq_mask: assert property (irq_o |-> |en)
        else $error("interrupt with nothing enabled");
    a_nmi_wake: assert property ($rose(mod_clk_run_o) |-> wake_nmi_o)
        else $error("stop wake without request");
    c_stop_wake: cover property ($rose(wake_nmi_o));
    c_wait_wake: cover property (in_wait ##1 tx_allowed_o);
    c_digital_loopback_sel: cover property (dl && tx_digital_out_i && rx_digital_in_o);
endmodule

// [verif/xcvr_model.sv]
`timescale 1ns/100ps
module xcvr_model (
    input  wire logic tx_i,
    input  wire logic loop_i,
    input  wire logic remote_i,
    output logic      rx_o
);
    // Passive bus reads low; in its own loopback the transceiver returns our drive only
    assign rx_o = loop_i ? tx_i : (tx_i | remote_i);
endmodule

// [verif/tb_j1850_low_power_loopback_ctl.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_j1850_low_power_loopback_ctl;
    import lp_ctl_pkg::*;
    localparam int unsigned IDLE = 20;
    typedef struct packed {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic              clk_i, rst_i, wr_i, rd_i, cpu_wait_i, cpu_stop_i, tx_digital_out_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, v;
    logic              bus_rx_i, bus_tx_o, rx_digital_in_o, tx_allowed_o;
    logic              mod_clk_run_o, irq_o, wake_nmi_o, remote, xloop;
    int                error_cnt, total_checks, n;
    row_t              rows[12];
    lp_loopback_ctl #(.IDLE_CYC(IDLE)) uut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .cpu_wait_i, .cpu_stop_i, .bus_rx_i, .bus_tx_o, .tx_digital_out_i,
        .rx_digital_in_o, .tx_allowed_o, .mod_clk_run_o, .irq_o, .wake_nmi_o);
    xcvr_model xcvr (.tx_i(bus_tx_o), .loop_i(xloop), .remote_i(remote), .rx_o(bus_rx_i));
    ////////////////////////////////////////////////////////////////////////////
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [4:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task pulse(input logic stop);
        @(posedge clk_i);
        cpu_stop_i <= stop;
        cpu_wait_i <= !stop;
        @(posedge clk_i);
        cpu_stop_i <= 1'b0;
        cpu_wait_i <= 1'b0;
        #1;
    endtask
    task hi(input logic clkrun);
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (n < 100 && !(clkrun ? mod_clk_run_o : tx_allowed_o));
    endtask
    task drive_bus(input logic b);
        @(posedge clk_i);
        remote <= b;
    endtask
    task complete_run;
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        error_cnt++;
        complete_run;
    end
    initial begin
        {rst_i, wr_i, rd_i, addr_i, wdata_i, cpu_wait_i, cpu_stop_i} = '0;
        rst_i = 1'b1;
        tx_digital_out_i = 1'b0; // Idle transmitter before any low power
        {remote, xloop, error_cnt, total_checks} = '0;
        rows = '{'{0, 5'h00, 8'h00, 8'h00}, '{0, 5'h04, 8'h00, 8'h00}, '{0, 5'h08, 8'h00, 8'h00},
            '{0, 5'h0C, 8'h00, 8'h00}, '{0, 5'h14, 8'h00, 8'h00}, '{0, 5'h18, 8'h00, 8'h00},
            '{1, 5'h1C, 8'h55, 8'h00}, '{1, 5'h08, 8'hFF, 8'h00}, '{1, 5'h10, 8'hFF, 8'h00},
            '{1, 5'h14, 8'h07, 8'h07}, '{1, 5'h04, 8'h02, 8'h02}, '{1, 5'h04, 8'h00, 8'h00}};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            `CHK("reg", rows[i].e, v)
        end
        // Wait mode and its wakeup
        pulse(1'b0);
        `CHK("txok", 1'b0, tx_allowed_o)
        `CHK("clkrun", 1'b1, mod_clk_run_o)
        drive_bus(1'b1);
        hi(1'b0);
        `CHK("wwake", 1'b1, tx_allowed_o)
        `CHK("irq", 1'b1, irq_o)
        rd(5'h0C);
        `CHK("stat", 8'h01, v)
        wr(5'h14, 8'h06);
        #1 `CHK("mask", 1'b0, irq_o)
        wr(5'h14, 8'h07);
        wr(5'h10, 8'h01);
        #1 `CHK("clr", 1'b0, irq_o)
        drive_bus(1'b0);
        // Stop mode entered from WAIT
        wr(5'h00, 8'h01);
        rd(5'h08);
        `CHK("vec0", VEC_NONE, v)
        pulse(1'b0);
        `CHK("stopclk", 1'b0, mod_clk_run_o)
        rd(5'h18);
        `CHK("mode", 8'h03, v)
        drive_bus(1'b1);
        hi(1'b1);
        `CHK("nmi", 1'b1, wake_nmi_o)
        rd(5'h08);
        `CHK("vec", VEC_WAKEUP, v)
        rd(5'h0C);
        `CHK("stat", 8'h02, v)
        rd(5'h00);
        `CHK("ctl1", 8'h01, v)
        rd(5'h14);
        `CHK("en", 8'h07, v)
        wr(5'h10, 8'h02);
        #1 `CHK("nmiclr", 1'b0, wake_nmi_o)
        drive_bus(1'b0);
        // Stop mode entered from STOP loses the waking message
        pulse(1'b1);
        `CHK("stopclk", 1'b0, mod_clk_run_o)
        drive_bus(1'b1);
        hi(1'b1);
        rd(5'h18);
        `CHK("lost", 8'h08, v)
        wr(5'h10, 8'h02);
        drive_bus(1'b0);
        // Detached by digital loopback, then a second reset
        rd(5'h08);
        `CHK("vec0", VEC_NONE, v)
        wr(5'h04, 8'h02);
        @(posedge clk_i);
        tx_digital_out_i <= 1'b1;
        #1 `CHK("dl_rx", 1'b1, rx_digital_in_o)
        `CHK("dl_tx", 1'b0, bus_tx_o)
        @(posedge clk_i);
        tx_digital_out_i <= 1'b0;
        pulse(1'b0);
        drive_bus(1'b1);
        repeat (10) @(posedge clk_i);
        #1 `CHK("nowake", 1'b0, mod_clk_run_o)
        @(posedge clk_i);
        rst_i <= 1'b1;
        remote <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(5'h00);
        `CHK("rst", 8'h00, v)
        // STOP with select 0 still gives wait mode
        pulse(1'b1);
        `CHK("sw_clk", 1'b1, mod_clk_run_o)
        `CHK("sw_tx", 1'b0, tx_allowed_o)
        drive_bus(1'b1);
        hi(1'b0);
        `CHK("sw_wake", 1'b1, tx_allowed_o)
        wr(5'h10, 8'h01);
        drive_bus(1'b0);
        // Analog loopback and the idle hunt after it
        wr(5'h04, 8'h01);
        @(posedge clk_i);
        xloop <= 1'b1;
        tx_digital_out_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 `CHK("al_tx", 1'b1, bus_tx_o)
        `CHK("al_rx", 1'b1, rx_digital_in_o)
        wr(5'h04, 8'h00);
        #1 `CHK("hunt", 1'b0, tx_allowed_o)
        @(posedge clk_i);
        {tx_digital_out_i, xloop, remote} <= 3'b001;
        repeat (30) @(posedge clk_i);
        #1 `CHK("busy", 1'b0, tx_allowed_o)
        drive_bus(1'b0);
        hi(1'b0);
        `CHK("idle", 1'b1, n >= IDLE && n <= IDLE + 5)
        rd(5'h0C);
        `CHK("found", 8'h04, v)
        complete_run;
    end
endmodule
bind lp_loopback_ctl lp_ctl_assertions #(.IDLE_CYC(IDLE_CYC)) chk (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cpu_wait_i(cpu_wait_i), .cpu_stop_i(cpu_stop_i), .bus_rx_i(bus_rx_i), .bus_tx_o(bus_tx_o),
    .tx_digital_out_i(tx_digital_out_i), .rx_digital_in_o(rx_digital_in_o),
    .tx_allowed_o(tx_allowed_o), .mod_clk_run_o(mod_clk_run_o), .irq_o(irq_o),
    .wake_nmi_o(wake_nmi_o));
